//--- include/pin_router_pkg.sv
// Constants for the peripheral pin router: offsets, fields, masks, reset values
// Behaviour
// - Logic event register bit 5 moves the second lookup-table output to its alternative pin.
// - Logic event register bit 4 moves the first lookup-table output to its alternative pin.
// - Logic event register bits 0 to 2 each connect one event channel to its pin; clear, the pin is undriven.
// - Serial register bit 4 moves the two-wire signals to their alternative pins.
// - Serial register bit 2 moves the SPI signals to their alternative pins.
// - Serial register bit 0 moves the USART signals to their alternative pins.
// - Timer A register bits 3 to 5 move waveform outputs 3 to 5 to alternative pins in split mode only.
// - In timer A normal mode, timer A register bits 3 to 5 have no effect on routing.
// - Timer A register bits 0 to 2 move waveform outputs 0 to 2 (low-byte channels in split mode).
// - Timer B register bit 0 moves the timer B output to its alternative pin.
// - After reset every routing register is zero: default pins, event outputs off.
package pin_router_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_LOGIC_EVENT = 8'h00;
    localparam logic [7:0] OFS_SERIAL = 8'h01;
    localparam logic [7:0] OFS_TIMER_A_WAVE = 8'h02;
    localparam logic [7:0] OFS_TIMER_B_OUT = 8'h03;
    // Reset value shared by all routing registers
    localparam logic [7:0] ROUTE_RESET = 8'h00;
    // Writable bit masks
    localparam logic [7:0] MASK_LOGIC_EVENT = 8'h37;
    localparam logic [7:0] MASK_SERIAL = 8'h15;
    localparam logic [7:0] MASK_TIMER_A_WAVE = 8'h3f;
    localparam logic [7:0] MASK_TIMER_B_OUT = 8'h01;
    // Field positions
    localparam int unsigned POS_LUT_B = 5;
    localparam int unsigned POS_LUT_A = 4;
    localparam int unsigned POS_EVENT_LO = 0;
    localparam int unsigned NUM_EVENT = 3;
    localparam int unsigned POS_TWO_WIRE = 4;
    localparam int unsigned POS_SPI = 2;
    localparam int unsigned POS_USART = 0;
    localparam int unsigned NUM_WAVE = 6;
    localparam int unsigned POS_WAVE_SPLIT_ONLY = 3;
    localparam int unsigned POS_TIMER_B = 0;
    // Signal counts per serial unit
    localparam int unsigned NUM_TWO_WIRE = 2;
    localparam int unsigned NUM_SPI = 4;
    localparam int unsigned NUM_USART = 4;
endpackage : pin_router_pkg

//--- verilog/pin_route_lane.sv
// One group of peripheral signals steered to a default or an alternative pin
`timescale 1ns/10ps
module pin_route_lane #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Per-signal choice, high selects the alternative pin
    input wire logic [WIDTH-1:0] sel,
    // Peripheral side
    input wire logic [WIDTH-1:0] periph_out,
    input wire logic [WIDTH-1:0] periph_oe,
    output logic [WIDTH-1:0] periph_in,
    // Default pin
    output logic [WIDTH-1:0] dflt_out,
    output logic [WIDTH-1:0] dflt_oe,
    input wire logic [WIDTH-1:0] dflt_in,
    // Alternative pin
    output logic [WIDTH-1:0] alt_out,
    output logic [WIDTH-1:0] alt_oe,
    input wire logic [WIDTH-1:0] alt_in
);
    logic [WIDTH-1:0] dflt_out_ff, dflt_oe_ff, alt_out_ff, alt_oe_ff;
    logic [WIDTH-1:0] dflt_meta_ff, dflt_sync_ff, alt_meta_ff, alt_sync_ff;
    logic [WIDTH-1:0] periph_in_ff;
    logic [WIDTH-1:0] nxt_periph_in;

    // An empty lane would leave every pin port without bits
    if (WIDTH < 1) begin : g_bad_width
        $error("pin_route_lane needs WIDTH of at least one");
    end

    // Unselected pin is released, so it never fights the other location
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            dflt_out_ff <= '0;
            dflt_oe_ff <= '0;
            alt_out_ff <= '0;
            alt_oe_ff <= '0;
        end else begin
            dflt_out_ff <= ~sel & periph_out;
            dflt_oe_ff <= ~sel & periph_oe;
            alt_out_ff <= sel & periph_out;
            alt_oe_ff <= sel & periph_oe;
        end
    end

    // Pin levels are asynchronous; only the second stage is read
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            dflt_meta_ff <= '0;
            dflt_sync_ff <= '0;
            alt_meta_ff <= '0;
            alt_sync_ff <= '0;
            periph_in_ff <= '0;
        end else begin
            dflt_meta_ff <= dflt_in;
            dflt_sync_ff <= dflt_meta_ff;
            alt_meta_ff <= alt_in;
            alt_sync_ff <= alt_meta_ff;
            periph_in_ff <= nxt_periph_in;
        end
    end

    // Return path follows the same choice as the drive path
    assign nxt_periph_in = (sel & alt_sync_ff) | (~sel & dflt_sync_ff);
    assign dflt_out = dflt_out_ff;
    assign dflt_oe = dflt_oe_ff;
    assign alt_out = alt_out_ff;
    assign alt_oe = alt_oe_ff;
    assign periph_in = periph_in_ff;
endmodule : pin_route_lane

//--- verilog/pin_router.sv
// Peripheral pin router: routing registers, event gating and pin lanes
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/10ps
module pin_router #(
    parameter int ADDR_W = 4
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Timer A mode, high in split mode
    input wire logic timer_a_split,
    // Lookup-table outputs
    input wire logic [1:0] lut_out,
    input wire logic [1:0] lut_oe,
    output logic [1:0] lut_dflt_out,
    output logic [1:0] lut_dflt_oe,
    output logic [1:0] lut_alt_out,
    output logic [1:0] lut_alt_oe,
    // Event channels and their pins
    input wire logic [2:0] event_chan,
    output logic [2:0] event_pin_out,
    output logic [2:0] event_pin_oe,
    // Two-wire interface
    input wire logic [1:0] twi_out,
    input wire logic [1:0] twi_oe,
    output logic [1:0] twi_in,
    output logic [1:0] twi_dflt_out,
    output logic [1:0] twi_dflt_oe,
    input wire logic [1:0] twi_dflt_in,
    output logic [1:0] twi_alt_out,
    output logic [1:0] twi_alt_oe,
    input wire logic [1:0] twi_alt_in,
    // SPI
    input wire logic [3:0] spi_out,
    input wire logic [3:0] spi_oe,
    output logic [3:0] spi_in,
    output logic [3:0] spi_dflt_out,
    output logic [3:0] spi_dflt_oe,
    input wire logic [3:0] spi_dflt_in,
    output logic [3:0] spi_alt_out,
    output logic [3:0] spi_alt_oe,
    input wire logic [3:0] spi_alt_in,
    // USART
    input wire logic [3:0] usart_out,
    input wire logic [3:0] usart_oe,
    output logic [3:0] usart_in,
    output logic [3:0] usart_dflt_out,
    output logic [3:0] usart_dflt_oe,
    input wire logic [3:0] usart_dflt_in,
    output logic [3:0] usart_alt_out,
    output logic [3:0] usart_alt_oe,
    input wire logic [3:0] usart_alt_in,
    // Timer A waveform outputs
    input wire logic [5:0] wave_out,
    input wire logic [5:0] wave_oe,
    output logic [5:0] wave_dflt_out,
    output logic [5:0] wave_dflt_oe,
    output logic [5:0] wave_alt_out,
    output logic [5:0] wave_alt_oe,
    // Timer B output
    input wire logic tb_out,
    input wire logic tb_oe,
    output logic tb_dflt_out,
    output logic tb_dflt_oe,
    output logic tb_alt_out,
    output logic tb_alt_oe
);
    logic [7:0] route_ctrl_logic_event_ff, route_ctrl_serial_ff;
    logic [7:0] route_ctrl_timer_a_wave_ff, route_ctrl_timer_b_out_ff;
    logic [7:0] nxt_route_ctrl_logic_event, nxt_route_ctrl_serial;
    logic [7:0] nxt_route_ctrl_timer_a_wave, nxt_route_ctrl_timer_b_out;
    logic [7:0] reg_rdata_ff, nxt_reg_rdata, read_mux;
    logic [2:0] event_pin_out_ff, event_pin_oe_ff;
    logic [2:0] nxt_event_pin_out;
    logic [2:0] event_pin_en;
    logic [5:0] wave_sel;
    wire hit_logic_event = reg_addr == ADDR_W'(pin_router_pkg::OFS_LOGIC_EVENT);
    wire hit_serial = reg_addr == ADDR_W'(pin_router_pkg::OFS_SERIAL);
    wire hit_timer_a_wave = reg_addr == ADDR_W'(pin_router_pkg::OFS_TIMER_A_WAVE);
    wire hit_timer_b_out = reg_addr == ADDR_W'(pin_router_pkg::OFS_TIMER_B_OUT);
    wire lookup_logic_out_b_alt = route_ctrl_logic_event_ff[pin_router_pkg::POS_LUT_B];
    wire lookup_logic_out_a_alt = route_ctrl_logic_event_ff[pin_router_pkg::POS_LUT_A];
    wire two_wire_alt_pins = route_ctrl_serial_ff[pin_router_pkg::POS_TWO_WIRE];
    wire serial_periph_alt_pins = route_ctrl_serial_ff[pin_router_pkg::POS_SPI];
    wire async_serial_alt_pins = route_ctrl_serial_ff[pin_router_pkg::POS_USART];
    wire timer_b_out_alt = route_ctrl_timer_b_out_ff[pin_router_pkg::POS_TIMER_B];

    // Offsets 0 to 3 need at least two address bits
    if (ADDR_W < 2) begin : g_bad_addr_w
        $error("pin_router needs ADDR_W of at least two");
    end

    // Write path, reserved bits masked off so they stay zero
    assign nxt_route_ctrl_logic_event = (reg_wr && hit_logic_event) ?
        (reg_wdata & pin_router_pkg::MASK_LOGIC_EVENT) : route_ctrl_logic_event_ff;
    assign nxt_route_ctrl_serial = (reg_wr && hit_serial) ?
        (reg_wdata & pin_router_pkg::MASK_SERIAL) : route_ctrl_serial_ff;
    assign nxt_route_ctrl_timer_a_wave = (reg_wr && hit_timer_a_wave) ?
        (reg_wdata & pin_router_pkg::MASK_TIMER_A_WAVE) : route_ctrl_timer_a_wave_ff;
    assign nxt_route_ctrl_timer_b_out = (reg_wr && hit_timer_b_out) ?
        (reg_wdata & pin_router_pkg::MASK_TIMER_B_OUT) : route_ctrl_timer_b_out_ff;

    // Read path; unmapped offsets and idle cycles read as zero
    assign read_mux = ({8{hit_logic_event}} & route_ctrl_logic_event_ff)
        | ({8{hit_serial}} & route_ctrl_serial_ff)
        | ({8{hit_timer_a_wave}} & route_ctrl_timer_a_wave_ff)
        | ({8{hit_timer_b_out}} & route_ctrl_timer_b_out_ff);
    assign nxt_reg_rdata = reg_rd ? read_mux : 8'h00;
    assign reg_rdata = reg_rdata_ff;

    // Routing registers all come up on default pins
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            route_ctrl_logic_event_ff <= pin_router_pkg::ROUTE_RESET;
            route_ctrl_serial_ff <= pin_router_pkg::ROUTE_RESET;
            route_ctrl_timer_a_wave_ff <= pin_router_pkg::ROUTE_RESET;
            route_ctrl_timer_b_out_ff <= pin_router_pkg::ROUTE_RESET;
            reg_rdata_ff <= 8'h00;
        end else begin
            route_ctrl_logic_event_ff <= nxt_route_ctrl_logic_event;
            route_ctrl_serial_ff <= nxt_route_ctrl_serial;
            route_ctrl_timer_a_wave_ff <= nxt_route_ctrl_timer_a_wave;
            route_ctrl_timer_b_out_ff <= nxt_route_ctrl_timer_b_out;
            reg_rdata_ff <= nxt_reg_rdata;
        end
    end

    // Event gating and timer A choice, one entry per channel
    genvar gi;
    generate
        for (gi = 0; gi < pin_router_pkg::NUM_EVENT; gi++) begin : g_event
            assign event_pin_en[gi] =
                route_ctrl_logic_event_ff[pin_router_pkg::POS_EVENT_LO + gi];
        end
        for (gi = 0; gi < pin_router_pkg::NUM_WAVE; gi++) begin : g_wave
            if (gi < pin_router_pkg::POS_WAVE_SPLIT_ONLY) begin : g_both
                // Same bit serves the low-byte channel in split mode
                assign wave_sel[gi] = route_ctrl_timer_a_wave_ff[gi];
            end else begin : g_split
                // Upper outputs only exist in split mode
                assign wave_sel[gi] =
                    route_ctrl_timer_a_wave_ff[gi] & timer_a_split;
            end
        end
    endgenerate

    // Disabled event pins are released and held low
    assign nxt_event_pin_out = event_chan & event_pin_en;
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            event_pin_out_ff <= 3'h0;
            event_pin_oe_ff <= 3'h0;
        end else begin
            event_pin_out_ff <= nxt_event_pin_out;
            event_pin_oe_ff <= event_pin_en;
        end
    end
    assign event_pin_out = event_pin_out_ff;
    assign event_pin_oe = event_pin_oe_ff;

    // Lookup-table outputs, each with its own location bit
    pin_route_lane #(.WIDTH(2)) u_lut (
        .clock(clock),
        .reset(reset),
        .sel({lookup_logic_out_b_alt, lookup_logic_out_a_alt}),
        .periph_out(lut_out),
        .periph_oe(lut_oe),
        .periph_in(),
        .dflt_out(lut_dflt_out),
        .dflt_oe(lut_dflt_oe),
        .dflt_in(2'h0),
        .alt_out(lut_alt_out),
        .alt_oe(lut_alt_oe),
        .alt_in(2'h0)
    );

    // Two-wire signals move as one group
    pin_route_lane #(.WIDTH(2)) u_twi (
        .clock(clock),
        .reset(reset),
        .sel({2{two_wire_alt_pins}}),
        .periph_out(twi_out),
        .periph_oe(twi_oe),
        .periph_in(twi_in),
        .dflt_out(twi_dflt_out),
        .dflt_oe(twi_dflt_oe),
        .dflt_in(twi_dflt_in),
        .alt_out(twi_alt_out),
        .alt_oe(twi_alt_oe),
        .alt_in(twi_alt_in)
    );

    // SPI signals move as one group
    pin_route_lane #(.WIDTH(4)) u_spi (
        .clock(clock),
        .reset(reset),
        .sel({4{serial_periph_alt_pins}}),
        .periph_out(spi_out),
        .periph_oe(spi_oe),
        .periph_in(spi_in),
        .dflt_out(spi_dflt_out),
        .dflt_oe(spi_dflt_oe),
        .dflt_in(spi_dflt_in),
        .alt_out(spi_alt_out),
        .alt_oe(spi_alt_oe),
        .alt_in(spi_alt_in)
    );

    // USART signals move as one group
    pin_route_lane #(.WIDTH(4)) u_usart (
        .clock(clock),
        .reset(reset),
        .sel({4{async_serial_alt_pins}}),
        .periph_out(usart_out),
        .periph_oe(usart_oe),
        .periph_in(usart_in),
        .dflt_out(usart_dflt_out),
        .dflt_oe(usart_dflt_oe),
        .dflt_in(usart_dflt_in),
        .alt_out(usart_alt_out),
        .alt_oe(usart_alt_oe),
        .alt_in(usart_alt_in)
    );

    // Timer A waveforms, split-mode qualified above
    pin_route_lane #(.WIDTH(6)) u_wave (
        .clock(clock),
        .reset(reset),
        .sel(wave_sel),
        .periph_out(wave_out),
        .periph_oe(wave_oe),
        .periph_in(),
        .dflt_out(wave_dflt_out),
        .dflt_oe(wave_dflt_oe),
        .dflt_in(6'h00),
        .alt_out(wave_alt_out),
        .alt_oe(wave_alt_oe),
        .alt_in(6'h00)
    );

    // Timer B output
    pin_route_lane #(.WIDTH(1)) u_tb (
        .clock(clock),
        .reset(reset),
        .sel(timer_b_out_alt),
        .periph_out(tb_out),
        .periph_oe(tb_oe),
        .periph_in(),
        .dflt_out(tb_dflt_out),
        .dflt_oe(tb_dflt_oe),
        .dflt_in(1'b0),
        .alt_out(tb_alt_out),
        .alt_oe(tb_alt_oe),
        .alt_in(1'b0)
    );

    // Checks wait two clean edges, so a past value never reaches back across a reset
    logic [1:0] checks_ready_ff;
    logic [1:0] nxt_checks_ready;
    assign nxt_checks_ready = {checks_ready_ff[0], 1'b1};
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            checks_ready_ff <= 2'h0;
        end else begin
            checks_ready_ff <= nxt_checks_ready;
        end
    end

    // Checks: pins follow the routing bits one cycle later; then reset value, write masking and read timing
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset || !checks_ready_ff[1]);

    AST_LUT_B_ALT: assert property (
        $past(route_ctrl_logic_event_ff[5]) |->
            !lut_dflt_oe[1] && lut_alt_oe[1] == $past(lut_oe[1])
            && lut_alt_out[1] == $past(lut_out[1]))
        else $error("second lookup output not on alternative pin");

    AST_LUT_A_DFLT: assert property (
        !$past(route_ctrl_logic_event_ff[4]) |->
            !lut_alt_oe[0] && lut_dflt_out[0] == $past(lut_out[0]))
        else $error("first lookup output not on default pin");

    AST_EVENT_OFF: assert property (
        !$past(route_ctrl_logic_event_ff[1]) |->
            !event_pin_oe[1] && !event_pin_out[1])
        else $error("disabled event pin is driven");

    AST_EVENT_ON: assert property (
        $past(route_ctrl_logic_event_ff[2]) |->
            event_pin_oe[2] && event_pin_out[2] == $past(event_chan[2]))
        else $error("enabled event pin does not follow its channel");

    AST_TWI_ALT: assert property (
        $past(route_ctrl_serial_ff[4]) |->
            twi_dflt_oe == 2'h0 && twi_alt_oe == $past(twi_oe))
        else $error("two-wire signals not on alternative pins");

    AST_SPI_ALT: assert property (
        $past(route_ctrl_serial_ff[2]) |->
            spi_dflt_oe == 4'h0 && spi_alt_out == $past(spi_out & 4'hf))
        else $error("SPI signals not on alternative pins");

    AST_USART_IN: assert property (
        $past(route_ctrl_serial_ff[0]) && $past(route_ctrl_serial_ff[0], 2)
            && $past(route_ctrl_serial_ff[0], 3) |->
            usart_in == $past(usart_alt_in, 3))
        else $error("USART input not taken from alternative pins");

    AST_WAVE_SPLIT: assert property (
        $past(route_ctrl_timer_a_wave_ff[3] && timer_a_split) |->
            !wave_dflt_oe[3] && wave_alt_oe[3] == $past(wave_oe[3]))
        else $error("split-mode waveform 3 not on alternative pin");

    AST_WAVE_NORMAL: assert property (
        !$past(timer_a_split) |-> wave_alt_oe[5:3] == 3'h0)
        else $error("upper waveform moved in normal mode");

    AST_WAVE_LOW: assert property (
        $past(route_ctrl_timer_a_wave_ff[0]) |->
            !wave_dflt_oe[0] && wave_alt_out[0] == $past(wave_out[0]))
        else $error("waveform 0 not on alternative pin");

    AST_TB_ALT: assert property (
        $past(route_ctrl_timer_b_out_ff[0]) |->
            !tb_dflt_oe && tb_alt_oe == $past(tb_oe))
        else $error("timer B output not on alternative pin");

    // Looked at on the release edge itself, so it may not wait for the other checks
    AST_RESET_ZERO: assert property (
        disable iff (1'b0) $fell(reset) |-> route_ctrl_logic_event_ff == 8'h00
            && route_ctrl_serial_ff == 8'h00 && route_ctrl_timer_a_wave_ff == 8'h00
            && route_ctrl_timer_b_out_ff == 8'h00)
        else $error("routing register not zero after reset");

    AST_RESERVED_ZERO: assert property (
        reg_wr && reg_addr == ADDR_W'(pin_router_pkg::OFS_SERIAL) ##1 !reg_wr ##1
            reg_rd && reg_addr == ADDR_W'(pin_router_pkg::OFS_SERIAL) && !reg_wr
            |=> reg_rdata == ($past(reg_wdata, 3) & pin_router_pkg::MASK_SERIAL))
        else $error("serial register readback not masked write");

    AST_READ_ONE_CYCLE: assert property (
        !$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside the answer cycle");

    COV_LUT_ALT: cover property (route_ctrl_logic_event_ff[5:4] == 2'b11);
    COV_EVENT_ALL: cover property (event_pin_oe == 3'h7 ##1 event_pin_out != 3'h0);
    COV_SPLIT_ALT: cover property (timer_a_split && wave_alt_oe[5:3] != 3'h0);
    COV_SERIAL_ALT: cover property (route_ctrl_serial_ff == 8'h15);
endmodule : pin_router

//--- test/pin_periph_model.sv
// Partner model: on-chip peripherals and pin pads around the router
`timescale 1ns/10ps
module pin_periph_model (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Freezes the pattern while the bench compares
    input wire logic hold,
    // Peripheral drive and pad levels
    output logic [40:0] periph_drive,
    output logic [19:0] pad_level
);
    logic [63:0] pat_ff;

    // Pattern shifts every unfrozen cycle, so stale routing shows as a mismatch
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            pat_ff <= 64'h9e37_79b9_7f4a_7c15;
        end else if (!hold) begin
            pat_ff <= {pat_ff[62:0], pat_ff[63] ^ pat_ff[62] ^ pat_ff[60] ^ pat_ff[59]};
        end
    end

    // Pads taken from other bits, so a pad never mirrors its own drive
    assign periph_drive = pat_ff[40:0];
    assign pad_level = ~pat_ff[63:44];
endmodule : pin_periph_model

//--- test/pin_router_bench.sv
// Self-checking bench for the peripheral pin router
`timescale 1ns/10ps
module pin_router_bench;
    // Clock, reset, register port and partner links
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic hold = 1'b1;
    logic timer_a_split = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic [40:0] pv;
    logic [19:0] pl;
    int n_fail = 0;
    int n_checks = 0;
    // Router outputs
    logic [1:0] lut_dflt_out, lut_dflt_oe, lut_alt_out, lut_alt_oe, twi_in;
    logic [1:0] twi_dflt_out, twi_dflt_oe, twi_alt_out, twi_alt_oe;
    logic [2:0] event_pin_out, event_pin_oe;
    logic [3:0] spi_in, spi_dflt_out, spi_dflt_oe, spi_alt_out, spi_alt_oe;
    logic [3:0] usart_in, usart_dflt_out, usart_dflt_oe, usart_alt_out, usart_alt_oe;
    logic [5:0] wave_dflt_out, wave_dflt_oe, wave_alt_out, wave_alt_oe;
    logic tb_dflt_out, tb_dflt_oe, tb_alt_out, tb_alt_oe;
    // Settings as {logic/event, serial, timer A, timer B}; all ones last
    logic [31:0] cfg [4] = '{32'h22100501, 32'h15052a00, 32'h00000000, 32'hffffffff};
    logic [7:0] masks [5] = '{8'h37, 8'h15, 8'h3f, 8'h01, 8'h00};

    always #2 clock = ~clock;

    pin_periph_model u_pin_periph_model (.clock(clock), .reset(reset), .hold(hold),
        .periph_drive(pv), .pad_level(pl));

    pin_router u_pin_router (.clock(clock), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .timer_a_split(timer_a_split), .lut_out(pv[1:0]), .lut_oe(pv[3:2]),
        .lut_dflt_out(lut_dflt_out), .lut_dflt_oe(lut_dflt_oe), .lut_alt_out(lut_alt_out),
        .lut_alt_oe(lut_alt_oe), .event_chan(pv[6:4]), .event_pin_out(event_pin_out),
        .event_pin_oe(event_pin_oe), .twi_out(pv[8:7]), .twi_oe(pv[10:9]), .twi_in(twi_in),
        .twi_dflt_out(twi_dflt_out), .twi_dflt_oe(twi_dflt_oe), .twi_dflt_in(pl[1:0]),
        .twi_alt_out(twi_alt_out), .twi_alt_oe(twi_alt_oe), .twi_alt_in(pl[3:2]),
        .spi_out(pv[14:11]), .spi_oe(pv[18:15]), .spi_in(spi_in),
        .spi_dflt_out(spi_dflt_out), .spi_dflt_oe(spi_dflt_oe), .spi_dflt_in(pl[7:4]),
        .spi_alt_out(spi_alt_out), .spi_alt_oe(spi_alt_oe), .spi_alt_in(pl[11:8]),
        .usart_out(pv[22:19]), .usart_oe(pv[26:23]), .usart_in(usart_in),
        .usart_dflt_out(usart_dflt_out), .usart_dflt_oe(usart_dflt_oe),
        .usart_dflt_in(pl[15:12]), .usart_alt_out(usart_alt_out),
        .usart_alt_oe(usart_alt_oe), .usart_alt_in(pl[19:16]),
        .wave_out(pv[32:27]), .wave_oe(pv[38:33]), .wave_dflt_out(wave_dflt_out),
        .wave_dflt_oe(wave_dflt_oe), .wave_alt_out(wave_alt_out), .wave_alt_oe(wave_alt_oe),
        .tb_out(pv[39]), .tb_oe(pv[40]), .tb_dflt_out(tb_dflt_out), .tb_dflt_oe(tb_dflt_oe),
        .tb_alt_out(tb_alt_out), .tb_alt_oe(tb_alt_oe));

    // Compare and count; case equality so unknowns never match
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One-cycle write; the idle cycle after it avoids a double drive of the strobe
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        @(posedge clock);
    endtask : wr

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata, exp);
        @(posedge clock);
    endtask : rd

    // Expected pin drive for settings r, split mode as currently driven
    task automatic check_routes(input logic [31:0] r);
        logic [1:0] ls;
        logic [5:0] ws;
        ls = r[29:28];
        ws = {r[13:11] & {3{timer_a_split}}, r[10:8]};
        #1;
        check({lut_alt_out, lut_alt_oe}, {pv[1:0] & ls, pv[3:2] & ls});
        check({lut_dflt_out, lut_dflt_oe}, {pv[1:0] & ~ls, pv[3:2] & ~ls});
        check({event_pin_out, event_pin_oe}, {pv[6:4] & r[26:24], r[26:24]});
        check({twi_alt_out, twi_alt_oe}, {pv[8:7] & {2{r[20]}}, pv[10:9] & {2{r[20]}}});
        check({twi_dflt_out, twi_dflt_oe}, r[20] ? 4'h0 : {pv[8:7], pv[10:9]});
        check(twi_in, r[20] ? pl[3:2] : pl[1:0]);
        check({spi_alt_out, spi_alt_oe}, r[18] ? {pv[14:11], pv[18:15]} : 8'h00);
        check({spi_dflt_out, spi_dflt_oe}, r[18] ? 8'h00 : {pv[14:11], pv[18:15]});
        check(spi_in, r[18] ? pl[11:8] : pl[7:4]);
        check({usart_alt_out, usart_alt_oe}, r[16] ? {pv[22:19], pv[26:23]} : 8'h00);
        check({usart_dflt_out, usart_dflt_oe}, r[16] ? 8'h00 : {pv[22:19], pv[26:23]});
        check(usart_in, r[16] ? pl[19:16] : pl[15:12]);
        check({wave_alt_out, wave_alt_oe}, {pv[32:27] & ws, pv[38:33] & ws});
        check({wave_dflt_out, wave_dflt_oe}, {pv[32:27] & ~ws, pv[38:33] & ~ws});
        check({tb_alt_out, tb_alt_oe}, {pv[39] & r[0], pv[40] & r[0]});
        check({tb_dflt_out, tb_dflt_oe}, {pv[39] & ~r[0], pv[40] & ~r[0]});
        @(posedge clock);
    endtask : check_routes

    // Program all four registers, move the pattern once, then let pads settle
    task automatic apply(input logic [31:0] r, input logic sp);
        for (int i = 0; i < 4; i++) begin
            wr(i[3:0], r[31 - 8 * i -: 8]);
        end
        timer_a_split <= sp;
        hold <= 1'b0;
        @(posedge clock);
        hold <= 1'b1;
        repeat (5) @(posedge clock);
        check_routes(r);
    endtask : apply

    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : give_verdict

    // Main sequence
    initial begin
        repeat (10) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        for (int i = 0; i < 4; i++) begin
            rd(i[3:0], 8'h00);
        end
        check_routes(32'h0);
        $display("test reset state done");
        // Reserved bits and the unmapped offset 4
        for (int i = 0; i < 5; i++) begin
            wr(i[3:0], 8'hff);
            rd(i[3:0], masks[i]);
        end
        $display("test register access done");
        // Every setting in both timer A modes
        for (int k = 0; k < 8; k++) begin
            apply(cfg[k / 2], k[0]);
        end
        $display("test routing done");
        // Reset in mid-run with every bit set
        reset <= 1'b1;
        @(posedge clock);
        reset <= 1'b0;
        repeat (5) @(posedge clock);
        check_routes(32'h0);
        rd(4'h2, 8'h00);
        $display("test second reset done");
        give_verdict();
    end
endmodule : pin_router_bench
